// file: src/qed_pkg.sv
package qed_pkg;

    // ********************************************************************
    // clock and timing
    // ********************************************************************
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned SAMPLE_HZ = 10_000;
    localparam int unsigned SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int unsigned SAMPLE_W = 12;
    localparam logic [SAMPLE_W-1:0] SAMPLE_LAST = SAMPLE_W'(SAMPLE_DIV - 1);
    localparam int unsigned PWRUP_MS = 50;
    localparam int unsigned PWRUP_CYCLES = (CLK_HZ / 1000) * PWRUP_MS;
    localparam int unsigned INCR_VALID_NS = 500;
    localparam int unsigned INCR_VALID_CYCLES = (INCR_VALID_NS * (CLK_HZ / 1_000_000)) / 1000;

    // ********************************************************************
    // angle format: fine unit is half a step; with thresholds +2 and -1 the step is the fine angle halved, no hysteresis
    // ********************************************************************
    localparam int unsigned FINE_W = 9;
    localparam int unsigned STEP_W = 8;
    localparam logic signed [FINE_W-1:0] UP_THRESH = 9'sh002;
    localparam logic signed [FINE_W-1:0] DOWN_THRESH = -9'sh001;
    localparam logic [STEP_W-1:0] INDEX_STEP = 8'h00;

    // ********************************************************************
    // field magnitude limits
    // ********************************************************************
    localparam int unsigned MAG_W = 8;
    localparam logic [MAG_W-1:0] MAG_MIN = 8'h20;
    localparam logic [MAG_W-1:0] MAG_MAX = 8'hE0;

    // ********************************************************************
    // one-time-programmable word
    // ********************************************************************
    localparam int unsigned OTP_BITS = 16;
    localparam int unsigned OTP_CNT_W = 5;
    localparam int unsigned OTP_ZERO_LSB = 0;
    localparam int unsigned OTP_REV_BIT = 9;
    localparam logic [OTP_BITS-1:0] OTP_BLANK = 16'h0000;

    typedef enum logic [1:0] {
        ST_PWR_WAIT = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN = 2'b11
    } qed_state_type;

endpackage : qed_pkg

// file: src/qed_otp_store.sv
`timescale 1ns/10ps
`default_nettype none
module qed_otp_store (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic otpBlank,
    input wire logic burn,
    input wire logic [qed_pkg::OTP_BITS-1:0] burnWord,
    output logic [qed_pkg::FINE_W-1:0] zeroFine,
    output logic reverseDirectionBit
);

    // fuse array survives nrst; only a blank part clears it
    logic [qed_pkg::OTP_BITS-1:0] fuse_q;
    logic [qed_pkg::OTP_BITS-1:0] active_q;
    logic loaded_q;

    // a burn that meets a clear in one cycle still lands
    always_ff @(posedge core_clk)
    begin
        if (burn)
            fuse_q <= (otpBlank ? qed_pkg::OTP_BLANK : fuse_q) | burnWord;
        else if (otpBlank)
            fuse_q <= qed_pkg::OTP_BLANK;
    end

    // new fuses take effect only after the next nrst release
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            active_q <= qed_pkg::OTP_BLANK;
            loaded_q <= 1'b0;
        end
        else if (!loaded_q)
        begin
            active_q <= fuse_q;
            loaded_q <= 1'b1;
        end
    end

    assign zeroFine = active_q[qed_pkg::OTP_ZERO_LSB +: qed_pkg::FINE_W];
    assign reverseDirectionBit = active_q[qed_pkg::OTP_REV_BIT];

endmodule : qed_otp_store
`default_nettype wire

// file: src/qed_encoder_out.sv
`timescale 1ns/10ps
`default_nettype none
module qed_encoder_out #(
    parameter int unsigned PWRUP_CYCLES = qed_pkg::PWRUP_CYCLES
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic powerUpHoldSelect,
    input wire logic [qed_pkg::FINE_W-1:0] angleIn,
    input wire logic [qed_pkg::MAG_W-1:0] fieldMag,
    input wire logic progEnable,
    input wire logic progClk,
    input wire logic progData,
    input wire logic otpBlank,
    input wire logic fieldRiseFlagI,
    input wire logic fieldFallFlagI,
    output logic chanA,
    output logic chanB,
    output logic chanIndex,
    output logic fieldRiseFlagO,
    output logic fieldRiseFlagOe,
    output logic fieldFallFlagO,
    output logic fieldFallFlagOe
);

    localparam int unsigned PWR_W = $clog2(PWRUP_CYCLES + 1);
    localparam logic [PWR_W-1:0] PWR_LAST = PWR_W'(PWRUP_CYCLES - 1);

    // ********************************************************************
    // helpers
    // ********************************************************************
    function automatic logic [qed_pkg::FINE_W-1:0] negFine(
        input logic [qed_pkg::FINE_W-1:0] v
    );
        negFine = qed_pkg::FINE_W'(~v + 1'b1);
    endfunction : negFine

    // ********************************************************************
    // sample divider and power-up timer
    // ********************************************************************
    logic [qed_pkg::SAMPLE_W-1:0] sampleCnt_q;
    logic [PWR_W-1:0] pwrCnt_q;
    logic pwrDone_q;
    wire sampleTick = (sampleCnt_q == qed_pkg::SAMPLE_LAST);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            sampleCnt_q <= '0;
        else if (sampleTick)
            sampleCnt_q <= '0;
        else
            sampleCnt_q <= sampleCnt_q + 1'b1;
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pwrCnt_q <= '0;
            pwrDone_q <= 1'b0;
        end
        else if (!pwrDone_q)
        begin
            pwrCnt_q <= pwrCnt_q + 1'b1;
            pwrDone_q <= (pwrCnt_q == PWR_LAST);
        end
    end

    // ********************************************************************
    // hold strap and output enable sequence
    // ********************************************************************
    logic strapTaken_q;
    logic holdStrap_q;
    qed_pkg::qed_state_type state_q;
    qed_pkg::qed_state_type state_d;

    // strap caught by a clocked process right after reset release
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            strapTaken_q <= 1'b0;
            holdStrap_q <= 1'b1;
        end
        else if (!strapTaken_q)
        begin
            strapTaken_q <= 1'b1;
            holdStrap_q <= powerUpHoldSelect;
        end
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            qed_pkg::ST_PWR_WAIT:
                if (pwrDone_q && strapTaken_q)
                    state_d = holdStrap_q ? qed_pkg::ST_HOLD : qed_pkg::ST_RUN;
            qed_pkg::ST_HOLD:
                if (!powerUpHoldSelect)
                    state_d = qed_pkg::ST_RUN;
            qed_pkg::ST_RUN:
                state_d = qed_pkg::ST_RUN;
            default:
                state_d = qed_pkg::ST_PWR_WAIT;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            state_q <= qed_pkg::ST_PWR_WAIT;
        else
            state_q <= state_d;
    end

    // ********************************************************************
    // zero position store and its programming shifter
    // ********************************************************************
    logic [qed_pkg::FINE_W-1:0] zeroFine;
    logic reverseDirectionBit;
    logic progClkPrev_q;
    logic progEnPrev_q;
    logic [qed_pkg::OTP_BITS-1:0] progShift_q;
    logic [qed_pkg::OTP_CNT_W-1:0] progCnt_q;
    // programming pins are sampled on core_clk; data taken at clock rise
    wire progRise = progClk && !progClkPrev_q && progEnable;
    wire progBurn = progEnPrev_q && !progEnable && (progCnt_q == qed_pkg::OTP_BITS);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            progClkPrev_q <= 1'b0;
            progEnPrev_q <= 1'b0;
            progShift_q <= qed_pkg::OTP_BLANK;
            progCnt_q <= '0;
        end
        else
        begin
            progClkPrev_q <= progClk;
            progEnPrev_q <= progEnable;
            if (!progEnable)
                progCnt_q <= '0;
            else if (progRise && progCnt_q != qed_pkg::OTP_BITS)
            begin
                progShift_q <= {progShift_q[qed_pkg::OTP_BITS-2:0], progData};
                progCnt_q <= progCnt_q + 1'b1;
            end
        end
    end

    qed_otp_store otpStore (
        .core_clk(core_clk),
        .nrst(nrst),
        .otpBlank(otpBlank),
        .burn(progBurn),
        .burnWord(progShift_q),
        .zeroFine(zeroFine),
        .reverseDirectionBit(reverseDirectionBit)
    );

    // ********************************************************************
    // position stepping, without hysteresis
    // ********************************************************************
    logic [qed_pkg::STEP_W-1:0] step_q;
    wire [qed_pkg::FINE_W-1:0] dirAngle =
        reverseDirectionBit ? negFine(angleIn) : angleIn;
    wire [qed_pkg::FINE_W-1:0] fineAngle = dirAngle + negFine(zeroFine);
    wire signed [qed_pkg::FINE_W-1:0] stepDiff = $signed(fineAngle + negFine({step_q, 1'b0}));
    wire moveUp = (stepDiff >= qed_pkg::UP_THRESH);
    wire moveDown = (stepDiff <= qed_pkg::DOWN_THRESH);

    // one step per sample; faster motion lags rather than skipping edges
    // while held the step tracks the angle, so enabling shows the true position
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            step_q <= '0;
        else if (state_q != qed_pkg::ST_RUN)
            step_q <= fineAngle[qed_pkg::FINE_W-1:1];
        else if (sampleTick)
        begin
            if (moveUp)
                step_q <= step_q + 1'b1;
            else if (moveDown)
                step_q <= step_q - 1'b1;
        end
    end

    // ********************************************************************
    // quadrature and index outputs
    // ********************************************************************
    wire running = (state_q == qed_pkg::ST_RUN);
    wire quadA = step_q[1] ^ step_q[0];
    wire quadB = step_q[1];
    wire atIndex = (step_q == qed_pkg::INDEX_STEP);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            chanA <= 1'b1;
            chanB <= 1'b1;
            chanIndex <= 1'b1;
        end
        else
        begin
            chanA <= running ? quadA : 1'b1;
            chanB <= running ? quadB : 1'b1;
            chanIndex <= running ? atIndex : 1'b1;
        end
    end

    // ********************************************************************
    // field diagnostics
    // ********************************************************************
    logic [qed_pkg::MAG_W-1:0] prevMag_q;
    logic riseOn_q;
    logic fallOn_q;
    wire magBad = (fieldMag < qed_pkg::MAG_MIN) || (fieldMag > qed_pkg::MAG_MAX);

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prevMag_q <= '0;
            riseOn_q <= 1'b0;
            fallOn_q <= 1'b0;
        end
        else if (sampleTick)
        begin
            prevMag_q <= fieldMag;
            riseOn_q <= magBad || (fieldMag > prevMag_q);
            fallOn_q <= magBad || (fieldMag < prevMag_q);
        end
    end

    // open drain: the pad only ever sinks
    assign fieldRiseFlagO = 1'b0;
    assign fieldRiseFlagOe = riseOn_q;
    assign fieldFallFlagO = 1'b0;
    assign fieldFallFlagOe = fallOn_q;

    // pad readback is not needed by this logic
    wire unusedPads = fieldRiseFlagI ^ fieldFallFlagI;

endmodule : qed_encoder_out
`default_nettype wire

// file: testbench/qed_encoder_out_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module qed_encoder_out_asserts #(
    parameter int unsigned PWRUP_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic powerUpHoldSelect,
    input wire logic [qed_pkg::MAG_W-1:0] fieldMag,
    input wire logic chanA,
    input wire logic chanB,
    input wire logic chanIndex,
    input wire logic fieldRiseFlagO,
    input wire logic fieldRiseFlagOe,
    input wire logic fieldFallFlagO,
    input wire logic fieldFallFlagOe
);
    // ****************
    // helper counters
    // ****************
    logic [31:0] upCnt_q;
    logic [11:0] phase_q;
    logic [12:0] badCnt_q;
    wire logic allHigh = chanA && chanB && chanIndex;
    wire logic magBad = (fieldMag < qed_pkg::MAG_MIN) || (fieldMag > qed_pkg::MAG_MAX);
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            upCnt_q <= 32'h0000_0000;
            phase_q <= 12'h000;
            badCnt_q <= 13'h0000;
        end
        else
        begin
            upCnt_q <= upCnt_q + 32'h0000_0001;
            phase_q <= (phase_q == qed_pkg::SAMPLE_LAST) ? 12'h000 : phase_q + 12'h001;
            badCnt_q <= (magBad && $stable(fieldMag)) ? badCnt_q + 13'h0001 : 13'h0000;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    // ****************
    // assertions
    // ****************
    index_alone_a: assert property (chanIndex && !allHigh |-> !chanA && !chanB)
        else $error("index high beside a or b");
    open_drain_a: assert property (!fieldRiseFlagO && !fieldFallFlagO)
        else $error("flag pin driven high");
    hold_stays_a: assert property (allHigh && powerUpHoldSelect |=> allHigh)
        else $error("hold left with select high");
    run_stays_a: assert property (!allHigh |=> !allHigh)
        else $error("outputs fell back to all high");
    pwr_early_a: assert property (upCnt_q < PWRUP_CYCLES |-> allHigh)
        else $error("outputs enabled before power-up time");
    pwr_done_a: assert property (
        upCnt_q == PWRUP_CYCLES + 6 && !powerUpHoldSelect |-> !allHigh)
        else $error("outputs not enabled after power-up time");
    valid_fast_a: assert property (
        $fell(powerUpHoldSelect) && allHigh && upCnt_q > PWRUP_CYCLES + 6 |-> ##[1:20] !allHigh)
        else $error("outputs not valid within 500 ns");
    quad_step_a: assert property (
        !allHigh && !$past(allHigh) && $changed({chanA, chanB})
        |-> (chanA != $past(chanA)) != (chanB != $past(chanB)))
        else $error("a and b changed together");
    // outputs may only move on the sample tick, far from this window
    sample_stand_a: assert property (
        !allHigh && !$past(allHigh) && phase_q > 12'h010 && phase_q < 12'hF00
        |-> $stable({chanA, chanB, chanIndex, fieldRiseFlagOe, fieldFallFlagOe}))
        else $error("outputs changed between samples");
    // a bad field must have stood over a whole sample period before it is judged
    flag_bad_a: assert property (
        badCnt_q > 13'h0FA0 |-> fieldRiseFlagOe && fieldFallFlagOe)
        else $error("bad field not flagged");
    cover property (chanIndex && !allHigh);
    cover property (fieldRiseFlagOe && fieldFallFlagOe);
    cover property (allHigh ##1 !allHigh);
endmodule : qed_encoder_out_asserts
bind qed_encoder_out qed_encoder_out_asserts #(.PWRUP_CYCLES(PWRUP_CYCLES))
    qed_encoder_out_asserts_inst (
    .core_clk(core_clk),
    .nrst(nrst),
    .powerUpHoldSelect(powerUpHoldSelect),
    .fieldMag(fieldMag),
    .chanA(chanA),
    .chanB(chanB),
    .chanIndex(chanIndex),
    .fieldRiseFlagO(fieldRiseFlagO),
    .fieldRiseFlagOe(fieldRiseFlagOe),
    .fieldFallFlagO(fieldFallFlagO),
    .fieldFallFlagOe(fieldFallFlagOe)
);
`default_nettype wire

// file: testbench/qed_quad_counter.sv
`timescale 1ns/10ps
`default_nettype none
module qed_quad_counter (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic chanA,
    input wire logic chanB,
    input wire logic chanIndex,
    output logic signed [15:0] posCount,
    output logic glitch
);
    // ****************
    // quadrature decode, up when a leads b
    // ****************
    logic [1:0] phase_q;
    logic valid_q;
    wire logic allHigh = chanA && chanB && chanIndex;
    wire logic [1:0] phaseNow = {chanB, chanA ^ chanB};
    wire logic [1:0] delta = phaseNow - phase_q;
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase_q <= 2'h0;
            valid_q <= 1'b0;
            posCount <= 16'sh0000;
            glitch <= 1'b0;
        end
        else
        begin
            phase_q <= phaseNow;
            // all high means power loss: resync instead of counting
            valid_q <= !allHigh;
            if (valid_q && !allHigh && delta == 2'h1)
                posCount <= posCount + 16'sh0001;
            if (valid_q && !allHigh && delta == 2'h3)
                posCount <= posCount - 16'sh0001;
            if (valid_q && !allHigh && delta == 2'h2)
                glitch <= 1'b1;
        end
    end
endmodule : qed_quad_counter
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic powerUpHoldSelect = 1'b1;
    logic [qed_pkg::FINE_W-1:0] angleIn = 9'h000;
    logic [qed_pkg::MAG_W-1:0] fieldMag = 8'h80;
    logic progEnable = 1'b0;
    logic progClk = 1'b0;
    logic progData = 1'b0;
    logic otpBlank = 1'b1;
    logic chanA, chanB, chanIndex, glitch;
    logic fieldRiseFlagO, fieldRiseFlagOe, fieldFallFlagO, fieldFallFlagOe;
    logic signed [15:0] posCount;
    wire logic risePin = fieldRiseFlagOe ? fieldRiseFlagO : 1'b1;
    wire logic fallPin = fieldFallFlagOe ? fieldFallFlagO : 1'b1;
    wire logic [2:0] flagPins = {glitch, risePin, fallPin};
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= nrst ? cyc + 1 : 0;
    qed_encoder_out #(.PWRUP_CYCLES(20)) qed_encoder_out_inst (.core_clk, .nrst,
        .powerUpHoldSelect, .angleIn, .fieldMag, .progEnable, .progClk, .progData, .otpBlank,
        .fieldRiseFlagI(risePin), .fieldFallFlagI(fallPin), .chanA, .chanB, .chanIndex,
        .fieldRiseFlagO, .fieldRiseFlagOe, .fieldFallFlagO, .fieldFallFlagOe);
    qed_quad_counter qed_quad_counter_inst (.core_clk, .nrst, .chanA, .chanB, .chanIndex,
        .posCount, .glitch);
    // ****************
    // shared tasks
    // ****************
    task automatic summarize;
        if (fails == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic checkPins(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: pins %b expected %b", $time, got, exp);
        end
    endtask : checkPins
    task automatic checkCount(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: count %h expected %h", $time, got, exp);
        end
    endtask : checkCount
    // waits to mid period, well away from the sample tick
    task automatic waitMid;
        int i;
        tick(1);
        for (i = 0; i < 4001 && cyc % 4000 != 2000; i++)
            tick(1);
        if (i == 4001)
        begin
            fails++;
            $display("wrong value at %0t: sample wait ran out", $time);
            summarize();
        end
    endtask : waitMid
    task automatic doReset(input logic strap);
        nrst = 1'b0;
        powerUpHoldSelect = strap;
        tick(5);
        nrst = 1'b1;
        tick(1);
        otpBlank = 1'b0;
    endtask : doReset
    // ****************
    // scenarios
    // ****************
    task automatic holdRelease;
        doReset(1'b1);
        tick(30);
        checkPins({chanA, chanB, chanIndex}, 3'h7);
        powerUpHoldSelect = 1'b0;
        tick(20);
        checkPins({chanA, chanB, chanIndex}, 3'h1);
        powerUpHoldSelect = 1'b1;
        tick(3);
        checkPins({chanA, chanB, chanIndex}, 3'h1);
    endtask : holdRelease
    task automatic rotate;
        logic [8:0] ang [7] = '{9'h002, 9'h004, 9'h006, 9'h009, 9'h008, 9'h007, 9'h008};
        logic [7:0] mag [7] = '{8'h80, 8'h80, 8'h60, 8'hF0, 8'h60, 8'h60, 8'h60};
        logic [2:0] cnt [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h3, 3'h4};
        // expected {glitch, rise pin, fall pin}; a pin reads low while its flag is on
        logic [2:0] flagExp [7] = '{3'h1, 3'h3, 3'h2, 3'h0, 3'h2, 3'h3, 3'h3};
        waitMid();
        for (int i = 0; i < 7; i++)
        begin
            angleIn = ang[i];
            fieldMag = mag[i];
            waitMid();
            checkCount(posCount, 16'(cnt[i]));
            checkPins(flagPins, flagExp[i]);
        end
    endtask : rotate
    task automatic burnZero(input logic [15:0] word);
        progEnable = 1'b1;
        tick(2);
        for (int i = 15; i >= 0; i--)
        begin
            progData = word[i];
            tick(2);
            progClk = 1'b1; // data settled before the rising edge
            tick(2);
            progClk = 1'b0;
        end
        tick(2);
        progEnable = 1'b0;
        tick(2);
    endtask : burnZero
    task automatic zeroReverse;
        burnZero(16'h0220);
        angleIn = 9'h1E0;
        doReset(1'b0);
        tick(30);
        checkPins({chanA, chanB, chanIndex}, 3'h1);
        waitMid();
        angleIn = 9'h1E2;
        waitMid();
        checkCount(posCount, 16'hFFFF);
        angleIn = 9'h1E0;
        waitMid();
        checkPins({chanA, chanB, chanIndex}, 3'h1);
        // too weak a field: both flags on after a full sample period
        fieldMag = 8'h10;
        waitMid();
        waitMid();
        checkPins(flagPins, 3'h0);
    endtask : zeroReverse
    initial
    begin
        doReset(1'b1);
        holdRelease();
        rotate();
        zeroReverse();
        summarize();
    end
endmodule : testbench
`default_nettype wire
